// File: lpt_ctrl.sv
// controller end: sequences calibration, leveling and mode writes
`timescale 1ns/100ps
// Contract
// - wait 20 cycles before first calibration
// - 10 cycles cke low before calibration
// - exit 10 cycles after cke high
// - hold cke high 10 cycles first
// - cke low 10 cycles after results
// - device returns result within 20 ns
// - device drives dq 3 ns after exit
// - calibration commands spaced delay plus two
// - strobe driven 25 ns after leveling
// - first strobe edge 40 ns later
// - leveling feedback within 0 to 20 ns
// - mode set gap max 14ns, 10 cycles
// - derated core timings add 1.875 ns
// - boot timings before configuration
// - reset command loads mode defaults
// - mode writes at least 10 cycles apart
module lpt_ctrl #(
  parameter int DQ_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  lpt_link_if.ctrl link,
  input wire logic i_start_cal,
  input wire logic i_start_level,
  input wire logic i_send_reset,
  input wire logic [DQ_W-1:0] i_cal_pattern,
  input wire logic i_derate,
  input wire logic i_configured,
  input wire logic [15:0] i_core_min_ps,
  output logic o_busy,
  output logic o_done,
  output logic [DQ_W-1:0] o_result,
  output logic [15:0] o_core_eff_ps,
  output logic o_boot_timing
);
  if (DQ_W < 1) begin : g_width_check
    $error("DQ_W must be positive");
  end

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    LPT_IDLE = 4'h0,
    LPT_CAL_MRW = 4'h1,
    LPT_CKE_LOW = 4'h3,
    LPT_CAL_CMD = 4'h2,
    LPT_CAL_WAIT = 4'h6,
    LPT_CKE_HIGH = 4'h7,
    LPT_CAL_EXIT = 4'h5,
    LPT_GAP = 4'h4,
    LPT_LVL_MRW = 4'hC,
    LPT_LVL_EDGE = 4'hD,
    LPT_LVL_WAIT = 4'hF,
    LPT_RST = 4'hE
  } lpt_state_t;

  lpt_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] sent_q, sent_d;
  logic cke_q, cke_d, dqs_q, dqs_d, dqsoe_q, dqsoe_d, done_q, done_d;
  logic [DQ_W-1:0] res_q, res_d;
  lpt_pkg::lpt_cmd_t cmd_d, cmd_q;
  lpt_pkg::lpt_mode_t mode_d, mode_q;

  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
    sent_d = (sent_q != 8'hFF) ? sent_q + 8'h01 : sent_q;
    cke_d = cke_q;
    dqs_d = dqs_q;
    dqsoe_d = dqsoe_q;
    done_d = 1'b0;
    res_d = res_q;
    cmd_d = lpt_pkg::LPT_CMD_NOP;
    mode_d = mode_q;
    case (st_q)
      LPT_IDLE: begin
        if (sent_q >= 8'(lpt_pkg::MODE_WRITE_GAP_CK)) begin
          if (i_send_reset) begin
            st_d = LPT_RST;
          end else if (i_start_cal) begin
            st_d = LPT_CAL_MRW;
          end else if (i_start_level) begin
            st_d = LPT_LVL_MRW;
          end
        end
      end
      LPT_RST: begin
        cmd_d = lpt_pkg::LPT_CMD_RESET;
        sent_d = 8'h00;
        cnt_d = 8'(lpt_pkg::MODE_SET_CMD_GAP_CK);
        st_d = LPT_GAP;
      end
      LPT_CAL_MRW: begin
        cmd_d = lpt_pkg::LPT_CMD_MRW;
        mode_d = lpt_pkg::LPT_MODE_CAL;
        sent_d = 8'h00;
        cnt_d = 8'(lpt_pkg::CAL_MODE_TO_CKE_LOW_CK);
        st_d = LPT_CKE_LOW;
      end
      LPT_CKE_LOW: begin
        if (cnt_q == 8'h00 && !cke_q && sent_q >=
            8'(lpt_pkg::CAL_MODE_TO_FIRST_CMD_CK)) begin
          st_d = LPT_CAL_CMD;
        end else if (cnt_q == 8'h00 && cke_q) begin
          cke_d = 1'b0;
          cnt_d = 8'(lpt_pkg::CKE_LOW_TO_FIRST_CAL_CK);
        end
      end
      LPT_CAL_CMD: begin
        cmd_d = lpt_pkg::LPT_CMD_CAL;
        cnt_d = 8'(lpt_pkg::CAL_CMD_GAP_CK);
        st_d = LPT_CAL_WAIT;
      end
      LPT_CAL_WAIT: begin
        if (link.dq_oe) begin
          res_d = link.dq_o;
        end
        if (cnt_q == 8'h00) begin
          cnt_d = 8'(lpt_pkg::CAL_RESULT_TO_CKE_HIGH_CK);
          st_d = LPT_CKE_HIGH;
        end
      end
      LPT_CKE_HIGH: begin
        if (cnt_q == 8'h00 && !cke_q) begin
          cke_d = 1'b1;
          cnt_d = 8'(lpt_pkg::CKE_HIGH_TO_CAL_EXIT_CK);
        end else if (cnt_q == 8'h00 && sent_q >=
            8'(lpt_pkg::MODE_WRITE_GAP_CK)) begin
          st_d = LPT_CAL_EXIT;
        end
      end
      LPT_CAL_EXIT: begin
        cmd_d = lpt_pkg::LPT_CMD_MRW;
        mode_d = lpt_pkg::LPT_MODE_CAL_EXIT;
        sent_d = 8'h00;
        cnt_d = 8'(lpt_pkg::MODE_SET_CMD_GAP_CK);
        done_d = 1'b1;
        st_d = LPT_GAP;
      end
      LPT_LVL_MRW: begin
        cmd_d = lpt_pkg::LPT_CMD_MRW;
        mode_d = lpt_pkg::LPT_MODE_LEVEL;
        sent_d = 8'h00;
        cnt_d = 8'(lpt_pkg::LEVEL_MODE_TO_FIRST_EDGE_CK);
        st_d = LPT_LVL_EDGE;
      end
      LPT_LVL_EDGE: begin
        if (sent_q >= 8'(lpt_pkg::LEVEL_DQS_EN_CK)) begin
          dqsoe_d = 1'b1;
        end
        if (cnt_q == 8'h00) begin
          dqs_d = 1'b1;
          cnt_d = 8'(lpt_pkg::LEVEL_FEEDBACK_DELAY_CK);
          st_d = LPT_LVL_WAIT;
        end
      end
      LPT_LVL_WAIT: begin
        if (cnt_q == 8'h00) begin
          res_d = link.dq_o;
          dqs_d = 1'b0;
          dqsoe_d = 1'b0;
          // closing write waits out gap
          // reuse the exit wait; cke is already high here
          st_d = LPT_CKE_HIGH;
          mode_d = lpt_pkg::LPT_MODE_NORMAL;
        end
      end
      LPT_GAP: begin
        if (cnt_q == 8'h00) begin
          st_d = LPT_IDLE;
        end
      end
      default: begin
        st_d = LPT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= LPT_IDLE;
      cnt_q <= 8'h00;
      sent_q <= 8'hFF;
      cke_q <= 1'b1;
      dqs_q <= 1'b0;
      dqsoe_q <= 1'b0;
      done_q <= 1'b0;
      res_q <= '0;
      cmd_q <= lpt_pkg::LPT_CMD_NOP;
      mode_q <= lpt_pkg::LPT_MODE_NORMAL;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sent_q <= sent_d;
      cke_q <= cke_d;
      dqs_q <= dqs_d;
      dqsoe_q <= dqsoe_d;
      done_q <= done_d;
      res_q <= res_d;
      cmd_q <= cmd_d;
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // derated core timing
  logic [15:0] core_q;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      core_q <= 16'h0000;
    end else begin
      core_q <= i_derate ?
        16'(i_core_min_ps + 16'(lpt_pkg::DERATE_PS)) : i_core_min_ps;
    end
  end
  assign o_boot_timing = !i_configured;

  assign link.cmd = cmd_q;
  assign link.mode = mode_q;
  assign link.ca = i_cal_pattern;
  assign link.cke = cke_q;
  assign link.dqs_o = dqs_q;
  assign link.dqs_oe = dqsoe_q;
  assign o_busy = (st_q != LPT_IDLE);
  assign o_done = done_q;
  assign o_result = res_q;
  assign o_core_eff_ps = core_q;
endmodule : lpt_ctrl

// File: lpt_pkg.sv
// package: shared constants and types for the training link ends
package lpt_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CAL_MODE_TO_FIRST_CMD_CK = 20;
  localparam int CKE_LOW_TO_FIRST_CAL_CK = 10;
  localparam int CKE_HIGH_TO_CAL_EXIT_CK = 10;
  localparam int CAL_MODE_TO_CKE_LOW_CK = 10;
  localparam int CAL_RESULT_TO_CKE_HIGH_CK = 10;
  localparam int CAL_RESULT_DELAY_NS = 20;
  localparam int CAL_RESULT_DELAY_CK =
    (CAL_RESULT_DELAY_NS / CLK_PERIOD_NS) > 0 ?
    (CAL_RESULT_DELAY_NS / CLK_PERIOD_NS) : 1;
  localparam int DQ_RELEASE_NS = 3;
  localparam int DQ_RELEASE_CK =
    (DQ_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CMD_GAP_CK =
    (CAL_RESULT_DELAY_NS + 2 * CLK_PERIOD_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int LEVEL_DQS_EN_NS = 25;
  localparam int LEVEL_DQS_EN_CK =
    (LEVEL_DQS_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEVEL_MODE_TO_FIRST_EDGE_NS = 40;
  localparam int LEVEL_MODE_TO_FIRST_EDGE_CK =
    (LEVEL_MODE_TO_FIRST_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEVEL_FEEDBACK_DELAY_NS = 20;
  localparam int LEVEL_FEEDBACK_DELAY_CK =
    (LEVEL_FEEDBACK_DELAY_NS / CLK_PERIOD_NS) > 0 ?
    (LEVEL_FEEDBACK_DELAY_NS / CLK_PERIOD_NS) : 1;
  localparam int MODE_SET_GAP_NS = 14;
  localparam int MODE_SET_MIN_CK = 10;
  localparam int MODE_SET_CMD_GAP_CK =
    ((MODE_SET_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) >
    MODE_SET_MIN_CK ?
    ((MODE_SET_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) :
    MODE_SET_MIN_CK;
  localparam int MODE_WRITE_GAP_CK = 10;
  // derating in picoseconds: 1.875 ns
  localparam int DERATE_PS = 1875;
  localparam logic [7:0] MR_RESET_VAL = 8'h00;
  // command codes on the link
  typedef enum logic [2:0] {
    LPT_CMD_NOP = 3'h0,
    LPT_CMD_MRW = 3'h1,
    LPT_CMD_CAL = 3'h2,
    LPT_CMD_RESET = 3'h3
  } lpt_cmd_t;
  // mode register write targets
  typedef enum logic [1:0] {
    LPT_MODE_NORMAL = 2'h0,
    LPT_MODE_CAL = 2'h1,
    LPT_MODE_CAL_EXIT = 2'h2,
    LPT_MODE_LEVEL = 2'h3
  } lpt_mode_t;
endpackage : lpt_pkg

// File: lpt_link_if.sv
// interface: link between controller end and device end
`timescale 1ns/100ps
interface lpt_link_if #(parameter int DQ_W = 8) ();
  lpt_pkg::lpt_cmd_t cmd;
  lpt_pkg::lpt_mode_t mode;
  logic [DQ_W-1:0] ca;
  logic cke;
  logic dqs_o;
  logic dqs_oe;
  logic [DQ_W-1:0] dq_o;
  logic dq_oe;
  modport ctrl (output cmd, mode, ca, cke, dqs_o, dqs_oe,
    input dq_o, dq_oe);
  modport dev (input cmd, mode, ca, cke, dqs_o, dqs_oe,
    output dq_o, dq_oe);
endinterface : lpt_link_if

// File: lpt_dev.sv
// device end: calibration echo, leveling feedback, mode reset
`timescale 1ns/100ps
module lpt_dev #(
  parameter int DQ_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  lpt_link_if.dev link,
  output logic o_cal_mode,
  output logic o_level_mode,
  output logic [7:0] o_mode_reg
);
  if (DQ_W < 1) begin : g_width_check
    $error("DQ_W must be positive");
  end

  ////////////////////////////////////////////////////////////////////////
  logic cal_q, cal_d, lvl_q, lvl_d, oe_q, oe_d;
  logic [DQ_W-1:0] dq_q, dq_d;
  logic [7:0] mr_q, mr_d;
  logic [3:0] rel_q, rel_d;

  always_comb begin
    cal_d = cal_q;
    lvl_d = lvl_q;
    oe_d = oe_q;
    dq_d = dq_q;
    mr_d = mr_q;
    rel_d = rel_q;
    if (link.cmd == lpt_pkg::LPT_CMD_RESET) begin
      mr_d = lpt_pkg::MR_RESET_VAL;
      cal_d = 1'b0;
      lvl_d = 1'b0;
    end else if (link.cmd == lpt_pkg::LPT_CMD_MRW) begin
      mr_d = {6'h00, link.mode};
      cal_d = (link.mode == lpt_pkg::LPT_MODE_CAL);
      lvl_d = (link.mode == lpt_pkg::LPT_MODE_LEVEL);
      if (cal_q && link.mode == lpt_pkg::LPT_MODE_CAL_EXIT) begin
        rel_d = 4'(lpt_pkg::DQ_RELEASE_CK);
      end
    end else if (cal_q && link.cmd == lpt_pkg::LPT_CMD_CAL) begin
      dq_d = link.ca;
      oe_d = 1'b1;
    end
    if (lvl_q && link.dqs_oe) begin
      dq_d = {DQ_W{link.dqs_o}};
      oe_d = 1'b1;
    end
    if (!cal_q && !lvl_q && rel_q != 4'h0) begin
      rel_d = rel_q - 4'h1;
    end else if (!cal_q && !lvl_q && rel_q == 4'h0 &&
        link.cmd != lpt_pkg::LPT_CMD_MRW) begin
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_q <= 1'b0;
      lvl_q <= 1'b0;
      oe_q <= 1'b0;
      dq_q <= '0;
      mr_q <= lpt_pkg::MR_RESET_VAL;
      rel_q <= 4'h0;
    end else begin
      cal_q <= cal_d;
      lvl_q <= lvl_d;
      oe_q <= oe_d;
      dq_q <= dq_d;
      mr_q <= mr_d;
      rel_q <= rel_d;
    end
  end

  assign link.dq_o = dq_q;
  assign link.dq_oe = oe_q;
  assign o_cal_mode = cal_q;
  assign o_level_mode = lvl_q;
  assign o_mode_reg = mr_q;
endmodule : lpt_dev

// File: lpt_properties.sv
// checker: timing relations seen on the training link
`timescale 1ns/100ps
module lpt_properties #(parameter int DQ_W = 8) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input lpt_pkg::lpt_cmd_t cmd,
  input lpt_pkg::lpt_mode_t mode,
  input wire logic [DQ_W-1:0] ca,
  input wire logic cke,
  input wire logic dqs_o,
  input wire logic dqs_oe,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dq_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic mrw;
  logic cal;
  logic [4:0] since_mrw_q;
  logic [4:0] since_cal_q;
  logic [4:0] cke_lo_q;
  logic [4:0] cke_hi_q;
  assign mrw = (cmd == lpt_pkg::LPT_CMD_MRW);
  assign cal = (cmd == lpt_pkg::LPT_CMD_CAL);
  ////////////////////////////////////////////////////////////////////////
  // saturating counters; reset reads as a long quiet spell
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      since_mrw_q <= 5'h1F;
      since_cal_q <= 5'h1F;
      cke_lo_q <= 5'h00;
      cke_hi_q <= 5'h1F;
    end else begin
      since_mrw_q <= mrw ? 5'h01 :
        since_mrw_q + {4'h0, since_mrw_q != 5'h1F};
      since_cal_q <= cal ? 5'h01 :
        since_cal_q + {4'h0, since_cal_q != 5'h1F};
      cke_lo_q <= cke ? 5'h00 : cke_lo_q + {4'h0, cke_lo_q != 5'h1F};
      cke_hi_q <= !cke ? 5'h00 : cke_hi_q + {4'h0, cke_hi_q != 5'h1F};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_cal;
    cal;
  endsequence
  sequence s_exit;
    mrw && mode == lpt_pkg::LPT_MODE_CAL_EXIT;
  endsequence
  sequence s_strobe_hi;
    dqs_oe && dqs_o ##1 dqs_oe;
  endsequence
  chk_cal_after_mode: assert property (
    s_cal |-> since_mrw_q >= 5'(lpt_pkg::CAL_MODE_TO_FIRST_CMD_CK))
    else $error("calibration too soon after mode write");
  chk_cke_low_first: assert property (
    s_cal |-> !cke && cke_lo_q >= 5'(lpt_pkg::CKE_LOW_TO_FIRST_CAL_CK))
    else $error("calibration without enough low clock enable");
  chk_exit_after_high: assert property (
    s_exit |-> cke && cke_hi_q >= 5'(lpt_pkg::CKE_HIGH_TO_CAL_EXIT_CK))
    else $error("calibration exit too soon after clock enable high");
  chk_cke_fall_gap: assert property (
    $fell(cke) |-> since_mrw_q >= 5'(lpt_pkg::CAL_MODE_TO_CKE_LOW_CK))
    else $error("clock enable fell too soon after mode write");
  chk_cke_rise_hold: assert property (
    $rose(cke) |-> cke_lo_q >= 5'(lpt_pkg::CAL_RESULT_TO_CKE_HIGH_CK) &&
      since_cal_q >= 5'(lpt_pkg::CAL_RESULT_TO_CKE_HIGH_CK +
      lpt_pkg::CAL_RESULT_DELAY_CK))
    else $error("clock enable raised too soon after results");
  chk_result_echo: assert property (
    s_cal |=> dq_oe && dq_o == $past(ca))
    else $error("calibration result late or wrong");
  chk_release_late: assert property (
    s_exit ##0 dq_oe |=> dq_oe)
    else $error("data released too early after exit");
  chk_release_done: assert property (
    s_exit |-> ##[1:4] !dq_oe)
    else $error("data never released after exit");
  chk_cal_spacing: assert property (
    s_cal |=> (!cal)[*2])
    else $error("calibration commands too close");
  chk_strobe_late: assert property (
    $rose(dqs_oe) |-> !mrw && since_mrw_q >= 5'(lpt_pkg::LEVEL_DQS_EN_CK))
    else $error("strobe driven too soon after leveling mode write");
  chk_edge_late: assert property (
    $rose(dqs_o) |-> !mrw &&
      since_mrw_q >= 5'(lpt_pkg::LEVEL_MODE_TO_FIRST_EDGE_CK))
    else $error("first strobe edge too soon after leveling mode write");
  chk_level_echo: assert property (
    s_strobe_hi |-> dq_oe && (&dq_o))
    else $error("leveling feedback missing");
  chk_mode_gap: assert property (
    mrw |-> since_mrw_q >= 5'(lpt_pkg::MODE_SET_CMD_GAP_CK) &&
      since_mrw_q >= 5'(lpt_pkg::MODE_WRITE_GAP_CK))
    else $error("mode writes too close");
endmodule : lpt_properties

// File: tb.sv
// testbench: both link ends joined, user sides driven and checked
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [15:0] core;
    logic derate;
    logic cfg;
    logic [15:0] eff;
  } lpt_row_t;
  logic i_mclk, i_resetn, start_cal, start_level, send_reset, derate, cfg;
  logic [7:0] pattern;
  logic [15:0] core_min;
  logic busy, done, boot, cal_mode, level_mode, dseen, cseen, lseen;
  logic [7:0] result, mode_reg;
  logic [15:0] eff;
  int mismatches = 0;
  int cmp_count = 0;
  lpt_row_t rows [4] = '{
    '{16'h0FA0, 1'b0, 1'b0, 16'h0FA0}, '{16'h0FA0, 1'b1, 1'b1, 16'h16F3},
    '{16'h0000, 1'b1, 1'b0, 16'h0753}, '{16'hE000, 1'b1, 1'b1, 16'hE753}};
  lpt_link_if #(.DQ_W(8)) link ();
  lpt_ctrl #(.DQ_W(8)) u_lpt_ctrl (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .link(link.ctrl), .i_start_cal(start_cal), .i_start_level(start_level),
    .i_send_reset(send_reset), .i_cal_pattern(pattern), .i_derate(derate),
    .i_configured(cfg), .i_core_min_ps(core_min), .o_busy(busy),
    .o_done(done), .o_result(result), .o_core_eff_ps(eff),
    .o_boot_timing(boot));
  lpt_dev #(.DQ_W(8)) u_lpt_dev (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .link(link.dev), .o_cal_mode(cal_mode), .o_level_mode(level_mode),
    .o_mode_reg(mode_reg));
  lpt_properties #(.DQ_W(8)) u_lpt_properties (.i_mclk(i_mclk),
    .i_resetn(i_resetn), .cmd(link.cmd), .mode(link.mode), .ca(link.ca),
    .cke(link.cke), .dqs_o(link.dqs_o), .dqs_oe(link.dqs_oe),
    .dq_o(link.dq_o), .dq_oe(link.dq_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // request held until taken, since refusals give no sign
  task automatic run(input logic [2:0] req);
    int n;
    n = 0;
    dseen = 1'b0;
    cseen = 1'b0;
    lseen = 1'b0;
    {send_reset, start_cal, start_level} = req;
    while (busy !== 1'b1 && n < 200) begin
      @(negedge i_mclk);
      n++;
    end
    {send_reset, start_cal, start_level} = 3'h0;
    while (busy === 1'b1 && n < 600) begin
      if (done === 1'b1) dseen = 1'b1;
      if (cal_mode === 1'b1) cseen = 1'b1;
      if (level_mode === 1'b1) lseen = 1'b1;
      @(negedge i_mclk);
      n++;
    end
    if (done === 1'b1) dseen = 1'b1;
    // a sequence runs well under 200 cycles; longer means a hang
    if (n >= 200) begin
      mismatches++;
      final_report();
    end
  endtask : run
  task automatic final_report;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    final_report();
  end
  initial begin
    {i_resetn, start_cal, start_level, send_reset, derate, cfg} = 6'h00;
    pattern = 8'hA5;
    core_min = 16'h0000;
    repeat (8) @(negedge i_mclk);
    check(mode_reg, lpt_pkg::MR_RESET_VAL);
    check({busy, link.cke, link.dq_oe, link.dqs_oe}, 4'h4);
    i_resetn = 1'b1;
    foreach (rows[i]) begin
      {core_min, derate, cfg} = {rows[i].core, rows[i].derate, rows[i].cfg};
      @(negedge i_mclk);
      check(eff, rows[i].eff);
      check(boot, !rows[i].cfg);
    end
    // two calibrations back to back; the write gap runs out in the gap state, so the second is taken at once
    run(3'b010);
    check(result, 8'hA5);
    check({dseen, cseen}, 2'h3);
    pattern = 8'h5A;
    run(3'b010);
    check(result, 8'h5A);
    check(dseen, 1'b1);
    run(3'b001);
    check({dseen, lseen}, 2'h3);
    check(level_mode, 1'b0);
    // strobe was high when sampled, so every data bit reads one
    check(result, 8'hFF);
    check(mode_reg, {6'h00, lpt_pkg::LPT_MODE_CAL_EXIT});
    run(3'b100);
    check(mode_reg, lpt_pkg::MR_RESET_VAL);
    // reset in mid calibration must leave the link quiet
    start_cal = 1'b1;
    repeat (15) @(negedge i_mclk);
    check({cal_mode, link.cke}, 2'h2);
    start_cal = 1'b0;
    i_resetn = 1'b0;
    @(negedge i_mclk);
    check({busy, cal_mode, link.cke, link.dq_oe}, 4'h2);
    i_resetn = 1'b1;
    run(3'b010);
    check(result, 8'h5A);
    final_report();
  end
endmodule : tb
